// ==== verilog/cgc_params.svh ====
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH
// =====================================================================
// register offsets
`define CGC_OFS_CTRL1       8'h00
`define CGC_OFS_CTRL2       8'h01
`define CGC_OFS_STATUS      8'h02
`define CGC_OFS_MODE_CTRL   8'h03
// =====================================================================
// reset values
`define CGC_CTRL1_RESET     8'h04
`define CGC_CTRL2_RESET     8'h40
`define CGC_MODE_CTRL_RESET 8'h00
// =====================================================================
// field positions, control one
`define CGC_SRC_HI          7
`define CGC_SRC_LO          6
`define CGC_REFERENCE_DIVIDER_HI         5
`define CGC_REFERENCE_DIVIDER_LO         3
`define CGC_INTERNAL_REF_SELECT_BIT       2
`define CGC_INTERNAL_REF_OUTPUT_ENABLE_BIT     1
`define CGC_IRSTOP_BIT      0
// =====================================================================
// field positions, control two
`define CGC_BUS_DIVIDER_HI         7
`define CGC_BUS_DIVIDER_LO         6
`define CGC_RANGE_BIT       5
`define CGC_HGO_BIT         4
`define CGC_LP_BIT          3
`define CGC_EKIND_BIT       2
`define CGC_EXTERNAL_REF_OUTPUT_ENABLE_BIT     1
`define CGC_ERSTOP_BIT      0
// =====================================================================
// field positions, own mode control register
`define CGC_PLLS_BIT        0
`define CGC_STOP_BIT        1
// =====================================================================
// timing counts
`define CGC_SYNC_STAGES     2
`endif

// ==== verilog/cgc_pkg.sv ====
package cgc_pkg;
    typedef enum logic [1:0]
    {
        CGC_SRC_LOOP = 2'h0,
        CGC_SRC_INT  = 2'h1,
        CGC_SRC_EXT  = 2'h2,
        CGC_SRC_PLL  = 2'h3
    } cgc_src_t;

    typedef enum
    {
        CGC_FEI,
        CGC_FEE,
        CGC_FBI,
        CGC_FBE,
        CGC_PEE,
        CGC_PBE,
        CGC_LOW_POWER_INTERNAL_MODE,
        CGC_LOW_POWER_EXTERNAL_MODE,
        CGC_STOP
    } cgc_mode_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cgc_bus_req_t;

    typedef struct packed
    {
        logic       ref_internal;
        logic       pll_select;
        logic       loop_enable;
        logic       int_ref_run;
        logic       ext_ref_run;
    } cgc_ctrl_t;
endpackage

// ==== verilog/cgc_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// power of two clock enable divider
module cgc_divider
#(
    parameter int SEL_W = 3
)
(
    input  wire logic             I_CLK,
    input  wire logic             I_NRST,
    input  wire logic [SEL_W-1:0] i_sel,
    output logic                  o_tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] mask;
    logic             wrap;

    assign mask     = CNT_W'((1 << i_sel) - 1);
    assign wrap     = (cnt_reg & mask) == mask;
    assign cnt_next = wrap ? '0 : cnt_reg + CNT_W'(1);
    assign o_tick   = wrap;

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule // cgc_divider
`default_nettype wire

// ==== verilog/cgc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// two flop level synchroniser
module cgc_sync
#(
    parameter int W = 1
)
(
    input  wire logic         I_CLK,
    input  wire logic         I_NRST,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
        end
        else
        begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
        end
    end

    assign o_q = s2_reg;
endmodule // cgc_sync
`default_nettype wire

// ==== verilog/cgc_ctrl.sv ====
// Contract
// [R1] source field 0 loop output, 1 internal reference, 2 external reference
// [R2] reserved source value 3 behaves as 0, the loop output
// [R3] reference divider divides by two to the power of its code, reset 0
// [R4] software keeps the divided reference in 31.25 to 39.0625 kHz for the fll
// [R5] software keeps the divided reference in 1 to 2 MHz for the pll
// [R6] reference select 1 picks internal, 0 external, as loop reference
// [R7] internal output enable drives the internal clock output, else inactive
// [R8] internal stop keep holds internal ref in stop if enabled or used
// [R9] bus divider divides by 1, 2, 4 or 8, reset divide by two
// [R10] range bit picks high oscillator range when set, low when clear
// [R11] gain bit picks high gain when set, low power when clear
// [R12] low power bit disables the loop in bypassed modes
// [R13] external kind bit requests crystal when set, driven clock when clear
// [R14] external output enable drives the external clock output
// [R15] external stop keep holds external ref in stop if enabled or used
// [R16] nine operating modes decoded from the controls
// [R17] no connection of this block leaves the chip
// [R18] clock mode status reports the source after synchronisation, pll as 3
// [R19] changing reference select or divider clears lock until reacquired
// [R20] both control registers read and write, reset to defaults
`timescale 1ns/1ps
`default_nettype none
`include "cgc_params.svh"
module cgc_ctrl
#(
    parameter int REFERENCE_DIVIDER_W = 3,
    parameter int BUS_DIVIDER_W = 2
)
(
    input  wire logic                 I_CLK,
    input  wire logic                 I_NRST,
    input  wire cgc_pkg::cgc_bus_req_t I_BUS,
    output logic [7:0]                O_RDATA,
    input  wire logic                 I_INT_REF_CLK,
    input  wire logic                 I_EXT_REF_CLK,
    input  wire logic                 I_LOOP_CLK,
    input  wire logic                 I_LOOP_LOCKED,
    input  wire logic                 I_STOP_REQ,
    output logic                      O_SYS_CLK_SRC,
    output logic                      O_REF_TICK,
    output logic                      O_BUS_TICK,
    output logic                      O_INTERNAL_REF_CLOCK_OUT,
    output logic                      O_EXTERNAL_REF_CLOCK_OUT,
    output logic                      O_OSC_HIGH_RANGE,
    output logic                      O_OSC_HIGH_GAIN,
    output logic                      O_CRYSTAL_REQUEST,
    output cgc_pkg::cgc_ctrl_t        O_CTRL,
    output logic                      O_LOCK
);
    import cgc_pkg::*;

    // =================================================================
    // registers
    logic [7:0]  ctrl1_reg;
    logic [7:0]  ctrl2_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        lock_reg;
    logic        lock_next;
    logic        was_int_reg;
    logic        was_ext_reg;

    // =================================================================
    // decode
    logic        wr1;
    logic        wr2;
    logic        wr_mode;
    logic [1:0]  src_field;
    logic [1:0]  src_eff;
    logic [REFERENCE_DIVIDER_W-1:0] reference_divider;
    logic [BUS_DIVIDER_W-1:0] bus_divider;
    logic        internal_ref_select;
    logic        plls;
    logic        low_power;
    logic        stop_mode;
    logic        bypassed;
    logic        int_mode;
    logic        ext_mode;
    logic        ref_change;
    logic        int_run;
    logic        ext_run;
    logic        int_ref_s;
    logic        ext_ref_s;
    logic        loop_clk_s;
    logic        locked_s;
    logic        stop_s;
    logic [1:0]  status_src;
    logic [1:0]  status_s;
    logic        ref_clk_sel;
    cgc_mode_t   mode;

    function automatic logic [1:0] src_decode(input logic [1:0] f);
        return (f == 2'h3) ? 2'h0 : f; // see [R2]
    endfunction

    assign wr1       = I_BUS.wr && I_BUS.addr == `CGC_OFS_CTRL1;
    assign wr2       = I_BUS.wr && I_BUS.addr == `CGC_OFS_CTRL2;
    assign wr_mode   = I_BUS.wr && I_BUS.addr == `CGC_OFS_MODE_CTRL;
    assign src_field = ctrl1_reg[`CGC_SRC_HI:`CGC_SRC_LO];
    assign src_eff   = src_decode(src_field); // see [R1]
    assign reference_divider      = ctrl1_reg[`CGC_REFERENCE_DIVIDER_HI:`CGC_REFERENCE_DIVIDER_LO];
    assign internal_ref_select     = ctrl1_reg[`CGC_INTERNAL_REF_SELECT_BIT];
    assign bus_divider      = ctrl2_reg[`CGC_BUS_DIVIDER_HI:`CGC_BUS_DIVIDER_LO];
    assign low_power = ctrl2_reg[`CGC_LP_BIT];
    assign plls      = mode_reg[`CGC_PLLS_BIT];
    assign stop_mode = stop_s;
    assign bypassed  = src_eff != 2'h0;
    assign ref_change = (wr1 && (I_BUS.wdata[`CGC_INTERNAL_REF_SELECT_BIT] != internal_ref_select
                        || I_BUS.wdata[`CGC_REFERENCE_DIVIDER_HI:`CGC_REFERENCE_DIVIDER_LO] != reference_divider))
                        || (wr_mode && I_BUS.wdata[`CGC_PLLS_BIT] != plls);

    // =================================================================
    // pin inputs pass two flops
    cgc_sync #(.W(5)) u_sync
    (
        .I_CLK  (I_CLK),
        .I_NRST (I_NRST),
        .i_d    ({I_INT_REF_CLK, I_EXT_REF_CLK, I_LOOP_CLK, I_LOOP_LOCKED,
                  I_STOP_REQ | mode_reg[`CGC_STOP_BIT]}),
        .o_q    ({int_ref_s, ext_ref_s, loop_clk_s, locked_s, stop_s})
    );

    // =================================================================
    // mode decode
    always_comb
    begin
        if (stop_mode)
            mode = CGC_STOP;
        else
            case (src_eff)
                2'h0:
                    mode = internal_ref_select ? CGC_FEI : (plls ? CGC_PEE : CGC_FEE);
                2'h1:
                    mode = low_power ? CGC_LOW_POWER_INTERNAL_MODE : CGC_FBI;
                2'h2:
                    mode = low_power ? CGC_LOW_POWER_EXTERNAL_MODE : (plls ? CGC_PBE : CGC_FBE);
                default:
                    mode = CGC_FEI;
            endcase // see [R16]
    end

    assign int_mode = mode == CGC_FEI || mode == CGC_FBI || mode == CGC_LOW_POWER_INTERNAL_MODE;
    assign ext_mode = mode == CGC_FEE || mode == CGC_FBE || mode == CGC_PEE
                   || mode == CGC_PBE || mode == CGC_LOW_POWER_EXTERNAL_MODE;

    // =================================================================
    // stop retention
    assign int_run = !stop_mode || (ctrl1_reg[`CGC_IRSTOP_BIT]
                   && (ctrl1_reg[`CGC_INTERNAL_REF_OUTPUT_ENABLE_BIT] || was_int_reg)); // see [R8]
    assign ext_run = !stop_mode || (ctrl2_reg[`CGC_ERSTOP_BIT]
                   && (ctrl2_reg[`CGC_EXTERNAL_REF_OUTPUT_ENABLE_BIT] || was_ext_reg)); // see [R15]

    // =================================================================
    // dividers for reference and bus ticks, both counting I_CLK
    cgc_divider #(.SEL_W(REFERENCE_DIVIDER_W)) u_ref_div
    (
        .I_CLK  (I_CLK),
        .I_NRST (I_NRST),
        .i_sel  (reference_divider),
        .o_tick (O_REF_TICK)
    ); // see [R3]

    cgc_divider #(.SEL_W(BUS_DIVIDER_W)) u_bus_div
    (
        .I_CLK  (I_CLK),
        .I_NRST (I_NRST),
        .i_sel  (bus_divider),
        .o_tick (O_BUS_TICK)
    ); // see [R9]

    // =================================================================
    // source routing
    assign ref_clk_sel = internal_ref_select ? int_ref_s : ext_ref_s; // see [R6]

    always_comb
    begin
        case (src_eff)
            2'h1:    O_SYS_CLK_SRC = int_ref_s;
            2'h2:    O_SYS_CLK_SRC = ext_ref_s;
            default: O_SYS_CLK_SRC = loop_clk_s;
        endcase // see [R1]
    end

    assign O_INTERNAL_REF_CLOCK_OUT = ctrl1_reg[`CGC_INTERNAL_REF_OUTPUT_ENABLE_BIT] && int_run
                                      && int_ref_s; // see [R7]
    assign O_EXTERNAL_REF_CLOCK_OUT = ctrl2_reg[`CGC_EXTERNAL_REF_OUTPUT_ENABLE_BIT] && ext_run
                                      && ext_ref_s; // see [R14]
    assign O_OSC_HIGH_RANGE  = ctrl2_reg[`CGC_RANGE_BIT]; // see [R10]
    assign O_OSC_HIGH_GAIN   = ctrl2_reg[`CGC_HGO_BIT]; // see [R11]
    assign O_CRYSTAL_REQUEST = ctrl2_reg[`CGC_EKIND_BIT]; // see [R13]

    assign O_CTRL.ref_internal = ref_clk_sel;
    assign O_CTRL.pll_select   = plls;
    assign O_CTRL.loop_enable  = !stop_mode && !(low_power && bypassed); // see [R12]
    assign O_CTRL.int_ref_run  = int_run;
    assign O_CTRL.ext_ref_run  = ext_run;
    assign O_LOCK              = lock_reg;

    // =================================================================
    // status, source passes a two flop crossing first
    assign status_src = (src_eff == 2'h0 && plls) ? 2'h3 : src_eff;

    cgc_sync #(.W(2)) u_stat_sync
    (
        .I_CLK  (I_CLK),
        .I_NRST (I_NRST),
        .i_d    (status_src),
        .o_q    (status_s)
    ); // see [R18]

    // lock clears on reference change, sets again when loop relocks
    assign lock_next = ref_change ? 1'b0
                     : (O_CTRL.loop_enable ? locked_s : 1'b0); // see [R19]

    always_comb
    begin
        case (I_BUS.addr)
            `CGC_OFS_CTRL1:     rdata_next = ctrl1_reg;
            `CGC_OFS_CTRL2:     rdata_next = ctrl2_reg;
            `CGC_OFS_STATUS:    rdata_next = {4'h0, status_s, lock_reg, internal_ref_select};
            `CGC_OFS_MODE_CTRL: rdata_next = mode_reg;
            default:            rdata_next = 8'h00;
        endcase
    end

    // =================================================================
    // register file
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ctrl1_reg <= `CGC_CTRL1_RESET; // see [R20]
            ctrl2_reg <= `CGC_CTRL2_RESET; // see [R9]
            mode_reg  <= `CGC_MODE_CTRL_RESET;
        end
        else
        begin
            if (wr1)
                ctrl1_reg <= I_BUS.wdata; // see [R20]
            if (wr2)
                ctrl2_reg <= I_BUS.wdata;
            if (wr_mode)
                mode_reg <= {6'h00, I_BUS.wdata[1:0]};
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            rdata_reg   <= 8'h00;
            lock_reg    <= 1'b0;
            was_int_reg <= 1'b1;
            was_ext_reg <= 1'b0;
        end
        else
        begin
            rdata_reg   <= I_BUS.rd ? rdata_next : 8'h00;
            lock_reg    <= lock_next;
            if (!stop_mode)
            begin
                was_int_reg <= int_mode;
                was_ext_reg <= ext_mode;
            end
        end
    end

    assign O_RDATA = rdata_reg; // see [R17]
endmodule // cgc_ctrl
`default_nettype wire

// ==== bench/cgc_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cgc_params.svh"
module cgc_chk
(
    input wire logic                  I_CLK,
    input wire logic                  I_NRST,
    input wire cgc_pkg::cgc_bus_req_t I_BUS,
    input wire logic [7:0]            O_RDATA,
    input wire logic                  O_OSC_HIGH_RANGE,
    input wire logic                  O_OSC_HIGH_GAIN,
    input wire logic                  O_CRYSTAL_REQUEST,
    input wire logic                  O_INTERNAL_REF_CLOCK_OUT,
    input wire logic                  O_EXTERNAL_REF_CLOCK_OUT,
    input wire logic                  O_REF_TICK,
    input wire logic                  O_BUS_TICK,
    input wire logic                  O_LOCK
);
    import cgc_pkg::*;
    // ==========
    // register shadow
    logic [7:0] sh1_reg;
    logic [7:0] sh2_reg;
    logic       wr1_sel;
    logic       wr2_sel;
    assign wr1_sel = I_BUS.wr && I_BUS.addr == `CGC_OFS_CTRL1;
    assign wr2_sel = I_BUS.wr && I_BUS.addr == `CGC_OFS_CTRL2;
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            sh1_reg <= `CGC_CTRL1_RESET;
            sh2_reg <= `CGC_CTRL2_RESET;
        end
        else
        begin
            if (wr1_sel) sh1_reg <= I_BUS.wdata;
            if (wr2_sel) sh2_reg <= I_BUS.wdata;
        end
    end
    // ==========
    // properties
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    property p_rd_ctrl2;
        I_BUS.rd && I_BUS.addr == `CGC_OFS_CTRL2 |=> O_RDATA == $past(sh2_reg);
    endproperty
    a_rd_ctrl2: assert property (p_rd_ctrl2) else $error("ctrl two read wrong");
    property p_unmapped;
        I_BUS.rd && I_BUS.addr > 8'h03 |=> O_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_idle;
        !$past(I_BUS.rd) |-> O_RDATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_range;
        O_OSC_HIGH_RANGE == sh2_reg[`CGC_RANGE_BIT];
    endproperty
    a_range: assert property (p_range) else $error("range out wrong");
    property p_gain;
        O_OSC_HIGH_GAIN == sh2_reg[`CGC_HGO_BIT];
    endproperty
    a_gain: assert property (p_gain) else $error("gain out wrong");
    property p_xtal;
        O_CRYSTAL_REQUEST == sh2_reg[`CGC_EKIND_BIT];
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal request wrong");
    property p_irout_off;
        !sh1_reg[1] && !$past(sh1_reg[1]) && !$past(sh1_reg[1], 2) |-> !O_INTERNAL_REF_CLOCK_OUT;
    endproperty
    a_irout_off: assert property (p_irout_off) else $error("internal out active");
    property p_erout_off;
        !sh2_reg[1] && !$past(sh2_reg[1]) && !$past(sh2_reg[1], 2) |-> !O_EXTERNAL_REF_CLOCK_OUT;
    endproperty
    a_erout_off: assert property (p_erout_off) else $error("external out active");
    property p_lock_clr;
        O_LOCK && wr1_sel && I_BUS.wdata[5:2] != sh1_reg[5:2] |=> !O_LOCK;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock kept after change");
    property p_ref_tick;
        O_REF_TICK && sh1_reg[5:3] != 3'h0 && $stable(sh1_reg) && !wr1_sel |=> !O_REF_TICK;
    endproperty
    a_ref_tick: assert property (p_ref_tick) else $error("reference tick too close");
    property p_bus_tick;
        O_BUS_TICK && sh2_reg[7:6] != 2'h0 && $stable(sh2_reg) && !wr2_sel |=> !O_BUS_TICK;
    endproperty
    a_bus_tick: assert property (p_bus_tick) else $error("bus tick too close");
    c_unmapped: cover property (I_BUS.rd && I_BUS.addr > 8'h03);
    c_lock_clr: cover property (O_LOCK && wr1_sel);
    c_bus_div8: cover property (O_BUS_TICK && sh2_reg[7:6] == 2'h3);
endmodule // cgc_chk
bind cgc_ctrl cgc_chk cgc_chk_i
(
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_BUS(I_BUS), .O_RDATA(O_RDATA),
    .O_OSC_HIGH_RANGE(O_OSC_HIGH_RANGE), .O_OSC_HIGH_GAIN(O_OSC_HIGH_GAIN),
    .O_CRYSTAL_REQUEST(O_CRYSTAL_REQUEST),
    .O_INTERNAL_REF_CLOCK_OUT(O_INTERNAL_REF_CLOCK_OUT),
    .O_EXTERNAL_REF_CLOCK_OUT(O_EXTERNAL_REF_CLOCK_OUT),
    .O_REF_TICK(O_REF_TICK), .O_BUS_TICK(O_BUS_TICK), .O_LOCK(O_LOCK)
);
`default_nettype wire

// ==== bench/cgc_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cgc_ctrl_tb;
    import cgc_pkg::*;
    logic         clk = 0;
    logic         nrst = 0;
    cgc_bus_req_t bus = '0;
    logic [2:0]   src = 3'h0;
    logic         lck = 0;
    logic         stp = 0;
    logic [7:0]   rdata;
    logic         o_src, o_rt, o_bt, o_io, o_eo, lk;
    cgc_ctrl_t    ctl;
    int           err_total = 0, checked = 0, cyc = 0, c, t;
    always #12.5 clk = ~clk;
    cgc_ctrl cgc_ctrl_i
    (
        .I_CLK(clk), .I_NRST(nrst), .I_BUS(bus), .O_RDATA(rdata),
        .I_INT_REF_CLK(src[1]), .I_EXT_REF_CLK(src[2]), .I_LOOP_CLK(src[0]),
        .I_LOOP_LOCKED(lck), .I_STOP_REQ(stp), .O_SYS_CLK_SRC(o_src),
        .O_REF_TICK(o_rt), .O_BUS_TICK(o_bt), .O_INTERNAL_REF_CLOCK_OUT(o_io),
        .O_EXTERNAL_REF_CLOCK_OUT(o_eo), .O_OSC_HIGH_RANGE(), .O_OSC_HIGH_GAIN(),
        .O_CRYSTAL_REQUEST(), .O_CTRL(ctl), .O_LOCK(lk)
    );
    // ==========
    // tasks
    task tally_and_finish;
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task nap(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= {a, d, 2'b10};
        @(posedge clk);
        bus <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        bus <= {a, 8'h00, 2'b01};
        @(posedge clk);
        bus <= '0;
        #1 chk(rdata & m, e);
    endtask
    task gap(input logic b, input int e);
        int n;
        @(negedge clk);
        while ((b ? o_bt : o_rt) !== 1'b1) @(negedge clk);
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while ((b ? o_bt : o_rt) !== 1'b1);
        end
        chk(n[7:0], e[7:0]);
    endtask
    // ==========
    // sequence
    initial
    begin
        nap(6);
        nrst <= 1'b1;
        rd(8'h00, 8'hff, 8'h04);
        rd(8'h01, 8'hff, 8'h40);
        wr(8'h10, 8'hff);
        wr(8'h01, 8'hbf);
        rd(8'h01, 8'hff, 8'hbf);
        rd(8'h10, 8'hff, 8'h00);
        wr(8'h01, 8'h24);
        wr(8'h01, 8'h10);
        for (c = 0; c < 8; c++)
        begin
            wr(8'h00, {2'h0, c[2:0], 3'h4});
            gap(1'b0, 1 << c);
        end
        for (c = 0; c < 4; c++)
        begin
            wr(8'h01, {c[1:0], 6'h00});
            gap(1'b1, 1 << c);
        end
        wr(8'h01, 8'h40);
        for (c = 0; c < 4; c++)
        begin
            wr(8'h00, {c[1:0], 6'h04});
            t = (c == 1) ? 1 : (c == 2) ? 2 : 0;
            src <= 3'h1 << t;
            nap(5);
            chk({7'h0, o_src}, 8'h01);
            src <= ~(3'h1 << t);
            nap(5);
            chk({7'h0, o_src}, 8'h00);
            rd(8'h02, 8'h0d, {4'h0, (c == 3) ? 2'h0 : c[1:0], 2'h1});
        end
        src <= 3'h7;
        wr(8'h00, 8'h06);
        nap(5);
        chk({7'h0, o_io}, 8'h01);
        wr(8'h00, 8'h04);
        nap(5);
        chk({7'h0, o_io}, 8'h00);
        wr(8'h01, 8'h42);
        nap(5);
        chk({7'h0, o_eo}, 8'h01);
        wr(8'h01, 8'h40);
        nap(5);
        chk({7'h0, o_eo}, 8'h00);
        wr(8'h00, 8'h44);
        wr(8'h01, 8'h48);
        nap(4);
        chk({7'h0, ctl.loop_enable}, 8'h00);
        wr(8'h01, 8'h40);
        nap(4);
        chk({7'h0, ctl.loop_enable}, 8'h01);
        stp <= 1'b1;
        wr(8'h00, 8'h07);
        wr(8'h01, 8'h43);
        nap(5);
        chk({6'h0, ctl.int_ref_run, ctl.ext_ref_run}, 8'h03);
        wr(8'h00, 8'h05);
        wr(8'h01, 8'h41);
        nap(3);
        chk({6'h0, ctl.int_ref_run, ctl.ext_ref_run}, 8'h02);
        wr(8'h00, 8'h06);
        wr(8'h01, 8'h42);
        nap(5);
        chk({6'h0, ctl.int_ref_run, ctl.ext_ref_run}, 8'h00);
        stp <= 1'b0;
        lck <= 1'b1;
        nap(6);
        rd(8'h02, 8'h02, 8'h02);
        wr(8'h00, 8'h0c);
        #1 chk({7'h0, lk}, 8'h00);
        nap(4);
        chk({7'h0, lk}, 8'h01);
        src <= 3'h2;
        nap(3);
        chk({7'h0, ctl.ref_internal}, 8'h01);
        wr(8'h00, 8'h08);
        wr(8'h03, 8'h01);
        nap(4);
        chk({6'h0, ctl.ref_internal, ctl.pll_select}, 8'h01);
        rd(8'h02, 8'h0c, 8'h0c);
        wr(8'h03, 8'h03);
        nap(4);
        chk({5'h0, ctl.loop_enable, ctl.int_ref_run, ctl.ext_ref_run}, 8'h00);
        nrst <= 1'b0;
        nap(2);
        nrst <= 1'b1;
        rd(8'h00, 8'hff, 8'h04);
        rd(8'h01, 8'hff, 8'h40);
        rd(8'h03, 8'hff, 8'h00);
        nap(2);
        tally_and_finish;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish;
        end
    end
endmodule // cgc_ctrl_tb
`default_nettype wire
